// ---- shared/sdx_consts.svh ----
`ifndef SDX_CONSTS_SVH
`define SDX_CONSTS_SVH
// register addresses (byte offsets)
`define SDX_A_DOUT_FETCH 8'h00
`define SDX_A_DOUT_STATE 8'h01
`define SDX_A_DIN_PROVIDE 8'h02
`define SDX_A_DIN_STATE 8'h03
`define SDX_A_STATUS 8'h04
`define SDX_A_CONTROL 8'h05
`define SDX_A_WD_RELOAD_LO 8'h06
`define SDX_A_WD_RELOAD_HI 8'h07
`define SDX_A_REQUEST 8'h08
`define SDX_A_DIAG_SWAP 8'h09
// status bits
`define SDX_ST_DIAG_FLAG 0
`define SDX_ST_DATA_EX 1
`define SDX_ST_WD_RUN 2
`define SDX_ST_WD_LOCK 3
// control bits
`define SDX_CT_STAT_DIAG 0
`define SDX_CT_CONTROLLED_WD_MODE 1
`define SDX_CT_CFG_OK 2
// request codes
`define SDX_RQ_START 8'h01
`define SDX_RQ_WD_EN 8'h02
`define SDX_RQ_WD_DIS 8'h03
`define SDX_RQ_WD_RST 8'h04
// diag buffer byte positions
`define SDX_DB_STAT1 6
`define SDX_DB_STAT2 7
`define SDX_DB_MADDR 9
`define SDX_CFG_FAULT_BIT 2
`define SDX_DUMMY_BYTE 8'h00
`define SDX_WD_TICK_NS 10000000
`define SDX_CLK_NS 20
`define SDX_WD_TICK_CYC (`SDX_WD_TICK_NS / `SDX_CLK_NS)
`define SDX_WD_ZERO 16'h0000
`define SDX_WD_RESET_VAL 16'hffff
`endif

// ---- shared/sdx_pkg.sv ----
`default_nettype none
package sdx_pkg;
  typedef enum logic [1:0] {
    SDX_WAIT_PRM = 2'b00,
    SDX_WAIT_CFG = 2'b01,
    SDX_DATA_EX = 2'b10
  } sdx_mode_t;
  typedef enum logic [1:0] {
    SDX_ACK_OK = 2'b00,
    SDX_ACK_RS = 2'b01,
    SDX_ACK_NR = 2'b10,
    SDX_ACK_HP = 2'b11
  } sdx_ack_t;
  typedef struct packed {
    logic valid;
    logic diag;
    logic [7:0] src_addr;
    logic [7:0] out_len;
  } sdx_req_t;
  typedef struct packed {
    logic valid;
    sdx_ack_t ack;
    logic dummy;
    logic [1:0] din_buf;
  } sdx_rsp_t;
endpackage
`default_nettype wire

// ---- rtl/sdx_diag_mem.sv ----
`default_nettype none
module sdx_diag_mem (
  // clock
  input wire logic clk,
  // write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // read port
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:255];
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ---- rtl/sdx_core.sv ----
//Contract
//- user diag swap sets pending flag, mirrored in status
//- pending flag makes next data exchange reply high priority
//- no input data configured: high priority reply with one zero byte
//- diagnosis fetch clears pending flag and pulses fetched interrupt
//- static diagnosis keeps pending flag set after fetch
//- flag clear on reset, start, controlled wd expiry; set entering exchange
//- diag buffer machine resets on start request or controlled wd expiry
//- swap inserts diag flags in bytes seven, eight, master address ten
//- data exchange only in exchange mode from locking master, else RS
//- output data too long: ignored, no resource reply
//- short output: cfg fault, leave master, still send input data
//- correct size: store output, reply from assigned input buffer
//- output rotates over three buffers, input over three
//- buffer state reads never exchange buffers
//- output fetch read exchanges, returns index, new and cleared flags
//- output state read: free, user, next, data fields high to low
//- input provide read exchanges, returns new user index one to three
//- input state read: four two-bit fields, free and next may be nil
//- exchange entered only after cfg ok and first input buffer
//- watchdog enable loads reload value and starts; disable any time
//- watchdog counts down each 10 ms; at zero leave, lock, event
//- watchdog reset request reloads programmed value
`default_nettype none
`include "sdx_consts.svh"
module sdx_core
  import sdx_pkg::*;
#(
  parameter int WD_TICK_CYC = `SDX_WD_TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // master link requests and answers
  input wire sdx_req_t link_req,
  output sdx_rsp_t link_rsp,
  // configuration
  input wire logic [7:0] master_addr,
  input wire logic [7:0] dout_len,
  input wire logic [7:0] din_len,
  // diag buffer readout toward the link
  input wire logic [7:0] diag_raddr,
  output logic [7:0] diag_rdata,
  // events
  output logic diag_fetched_irq,
  output logic wd_expired_event
);
  sdx_mode_t mode_q;
  logic diag_flag_q, cfg_fault_q, stat_diag_q, dp_ctrl_q, cfg_ok_q;
  logic din_valid_q, wd_run_q, wd_lock_q, cleared_q, dbuf_q;
  logic [15:0] wd_q, wd_reload_q;
  logic [31:0] tick_q;
  logic [1:0] of_q, ou_q, on_q, od_q;
  logic [1:0] if_q, iu_q, in_q, id_q;
  logic [7:0] rdata_d;
  logic start, wd_expire, wdx_ok, wdx_short, wdx_ok_long;
  logic rd_out, rd_in, diag_swap, req_cmd;
  logic enter_dx, leave_master, ctl_expire;
  logic mem_we;
  logic [7:0] mem_waddr, mem_wdata, stat1, stat2;

  function automatic logic hit(input logic [7:0] a);
    hit = (reg_addr == a);
  endfunction

  // first non-nil buffer index of two candidates
  function automatic logic [1:0] pick(input logic [1:0] a, b);
    pick = (a != 2'h0) ? a : b;
  endfunction

  assign req_cmd = reg_wr && hit(`SDX_A_REQUEST);
  assign start = req_cmd && reg_wdata == `SDX_RQ_START;
  assign wd_expire = wd_run_q && !wd_lock_q && wd_q == `SDX_WD_ZERO;
  assign rd_out = reg_rd && hit(`SDX_A_DOUT_FETCH);
  assign rd_in = reg_rd && hit(`SDX_A_DIN_PROVIDE);
  assign diag_swap = reg_wr && hit(`SDX_A_DIAG_SWAP);
  assign wdx_ok = link_req.valid && !link_req.diag && mode_q == SDX_DATA_EX
    && link_req.src_addr == master_addr;
  assign wdx_ok_long = wdx_ok && link_req.out_len > dout_len;
  assign wdx_short = wdx_ok && link_req.out_len < dout_len && !wdx_ok_long;
  // leaving the master: short output or watchdog expiry
  assign leave_master = wd_expire || wdx_short;
  assign enter_dx = mode_q == SDX_WAIT_CFG && din_valid_q && !wd_expire;
  // expiry in controlled mode restarts the diagnosis side
  assign ctl_expire = wd_expire && dp_ctrl_q;

  // protocol mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= SDX_WAIT_PRM;
    end else if (start || leave_master) begin
      mode_q <= SDX_WAIT_PRM;
    end else if (mode_q == SDX_WAIT_PRM && cfg_ok_q) begin
      mode_q <= SDX_WAIT_CFG;
    end else if (enter_dx) begin
      mode_q <= SDX_DATA_EX;
    end
  end

  // first input buffer provided since start or leaving the master
  always_ff @(posedge clk) begin
    // a new first input buffer is needed after leaving the master
    if (!rst_n || start || leave_master) begin
      din_valid_q <= 1'b0;
    end else if (rd_in) begin
      din_valid_q <= 1'b1;
    end
  end

  // diagnosis pending flag
  always_ff @(posedge clk) begin
    if (!rst_n || start || ctl_expire) begin
      diag_flag_q <= 1'b0;
    end else if (diag_swap) begin
      diag_flag_q <= 1'b1;
    end else if (enter_dx) begin
      diag_flag_q <= 1'b1;
    end else if (link_req.valid && link_req.diag && !stat_diag_q) begin
      diag_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      diag_fetched_irq <= 1'b0;
    end else begin
      diag_fetched_irq <= link_req.valid && link_req.diag;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || start) begin
      cfg_fault_q <= 1'b0;
    end else if (wdx_short) begin
      cfg_fault_q <= 1'b1;
    end
  end

  // control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_diag_q <= 1'b0;
      dp_ctrl_q <= 1'b0;
      cfg_ok_q <= 1'b0;
      wd_reload_q <= `SDX_WD_RESET_VAL;
    end else if (reg_wr) begin
      if (hit(`SDX_A_CONTROL)) begin
        stat_diag_q <= reg_wdata[`SDX_CT_STAT_DIAG];
        dp_ctrl_q <= reg_wdata[`SDX_CT_CONTROLLED_WD_MODE];
        cfg_ok_q <= reg_wdata[`SDX_CT_CFG_OK];
      end
      if (hit(`SDX_A_WD_RELOAD_LO)) begin
        wd_reload_q[7:0] <= reg_wdata;
      end
      if (hit(`SDX_A_WD_RELOAD_HI)) begin
        wd_reload_q[15:8] <= reg_wdata;
      end
    end
  end

  // diag buffer state: swap marker, reset at start or controlled expiry
  always_ff @(posedge clk) begin
    if (!rst_n || start || ctl_expire) begin
      dbuf_q <= 1'b0;
    end else if (diag_swap) begin
      dbuf_q <= 1'b1;
    end
  end

  // swap writes flags and master address into the diag buffer
  assign stat1 = {1'b0, 1'b0, 1'b0, 1'b0, reg_wdata[3], cfg_fault_q,
    mode_q != SDX_DATA_EX, 1'b0};
  assign stat2 = {5'h00, 1'b1, stat_diag_q, 1'b0};
  logic [1:0] wseq_q;
  always_ff @(posedge clk) begin
    if (!rst_n || start || ctl_expire) begin
      wseq_q <= 2'h0;
    end else if (diag_swap) begin
      wseq_q <= 2'h1;
    end else if (wseq_q != 2'h0) begin
      wseq_q <= wseq_q + 2'h1;
    end
  end
  always_comb begin
    mem_we = wseq_q != 2'h0 || diag_swap;
    mem_waddr = 8'(`SDX_DB_STAT1);
    mem_wdata = stat1;
    if (wseq_q == 2'h1) begin
      mem_waddr = 8'(`SDX_DB_STAT2);
      mem_wdata = stat2;
    end else if (wseq_q == 2'h2) begin
      mem_waddr = 8'(`SDX_DB_MADDR);
      mem_wdata = master_addr;
    end else if (wseq_q == 2'h3) begin
      mem_we = 1'b0;
    end
  end

  sdx_diag_mem u_mem (
    .clk(clk),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(diag_raddr),
    .rdata(diag_rdata)
  );

  // output buffer rotation over three buffers, code 0 means nil
  always_ff @(posedge clk) begin
    if (!rst_n || start) begin
      od_q <= 2'h1;
      on_q <= 2'h0;
      of_q <= 2'h3;
      ou_q <= 2'h2;
      cleared_q <= 1'b0;
    end else if (wdx_ok && !wdx_ok_long) begin
      // fresh output moves D to N; a free buffer, else old N, refills D
      if (on_q != 2'h0 || of_q != 2'h0) begin
        on_q <= od_q;
        od_q <= pick(of_q, on_q);
        of_q <= (of_q != 2'h0) ? 2'h0 : of_q;
      end
      // zero-length output hands over substitute values
      cleared_q <= link_req.out_len == 8'h00 && dout_len != 8'h00;
    end else if (rd_out) begin
      if (on_q != 2'h0) begin
        ou_q <= on_q;
        on_q <= 2'h0;
        of_q <= ou_q;
      end
    end
  end

  // input buffer rotation over three buffers
  always_ff @(posedge clk) begin
    if (!rst_n || start) begin
      iu_q <= 2'h1;
      id_q <= 2'h2;
      if_q <= 2'h3;
      in_q <= 2'h0;
    end else if (rd_in) begin
      in_q <= iu_q;
      iu_q <= pick(if_q, in_q);
      if_q <= 2'h0;
    // a reply takes the fresh N as D and frees the old D
    end else if (wdx_ok && !wdx_ok_long && in_q != 2'h0) begin
      id_q <= in_q;
      in_q <= 2'h0;
      if_q <= id_q;
    end
  end

  // link response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link_rsp <= '0;
    end else begin
      link_rsp.valid <= link_req.valid && !link_req.diag;
      // dummy byte only rides on a high priority reply
      link_rsp.dummy <= din_len == 8'h00 && diag_flag_q && wdx_ok
        && !wdx_ok_long;
      link_rsp.din_buf <= id_q;
      if (!wdx_ok) begin
        link_rsp.ack <= SDX_ACK_RS;
      end else if (wdx_ok_long) begin
        link_rsp.ack <= SDX_ACK_NR;
      end else if (diag_flag_q) begin
        link_rsp.ack <= SDX_ACK_HP;
      end else begin
        link_rsp.ack <= SDX_ACK_OK;
      end
    end
  end

  // user watchdog
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wd_run_q <= 1'b0;
      wd_lock_q <= 1'b0;
      wd_q <= `SDX_WD_RESET_VAL;
      tick_q <= '0;
      wd_expired_event <= 1'b0;
    end else begin
      wd_expired_event <= wd_expire;
      // base tick restarts on enable only; a reset request does not restart it
      tick_q <= (tick_q == 32'(WD_TICK_CYC - 1)) ? '0 : tick_q + 32'h1;
      if (req_cmd && reg_wdata == `SDX_RQ_WD_EN) begin
        wd_run_q <= 1'b1;
        wd_lock_q <= 1'b0;
        wd_q <= wd_reload_q;
        tick_q <= '0;
      end else if (req_cmd && reg_wdata == `SDX_RQ_WD_DIS) begin
        wd_run_q <= 1'b0;
      end else if (req_cmd && reg_wdata == `SDX_RQ_WD_RST) begin
        wd_q <= wd_reload_q;
      end else if (wd_expire) begin
        wd_lock_q <= 1'b1;
      end else if (wd_run_q && !wd_lock_q &&
          tick_q == 32'(WD_TICK_CYC - 1)) begin
        wd_q <= wd_q - 16'h0001;
      end
    end
  end

  // register read mux; state reads have no side effect
  // fetch and provide report the index after the exchange
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr)
      `SDX_A_DOUT_STATE: rdata_d = {of_q, ou_q, on_q, od_q};
      `SDX_A_DIN_STATE: rdata_d = {if_q, iu_q, in_q, id_q};
      `SDX_A_DOUT_FETCH: rdata_d = {4'h0, cleared_q, on_q != 2'h0,
        pick(on_q, ou_q)};
      `SDX_A_DIN_PROVIDE: rdata_d = {6'h00, pick(if_q, in_q)};
      `SDX_A_STATUS: rdata_d = {3'h0, dbuf_q, wd_lock_q, wd_run_q,
        mode_q == SDX_DATA_EX, diag_flag_q};
      `SDX_A_CONTROL: rdata_d = {5'h00, cfg_ok_q, dp_ctrl_q, stat_diag_q};
      `SDX_A_WD_RELOAD_LO: rdata_d = wd_reload_q[7:0];
      `SDX_A_WD_RELOAD_HI: rdata_d = wd_reload_q[15:8];
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// ---- tb/sdx_core_sva.sv ----
`default_nettype none
`include "sdx_consts.svh"
module sdx_core_chk
  import sdx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire sdx_req_t link_req,
  input wire sdx_rsp_t link_rsp,
  input wire logic [7:0] master_addr,
  input wire logic [7:0] dout_len,
  input wire logic [7:0] din_len,
  input wire logic diag_fetched_irq,
  input wire logic wd_expired_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RSP: assert property (
    link_req.valid && !link_req.diag |=> link_rsp.valid)
    else $error("request not answered");
  AST_IRQ: assert property (
    link_req.valid && link_req.diag |=> diag_fetched_irq ##1 !diag_fetched_irq)
    else $error("fetched pulse wrong");
  AST_SRC: assert property (
    link_req.valid && !link_req.diag && link_req.src_addr != master_addr
    |=> link_rsp.ack == SDX_ACK_RS)
    else $error("foreign master accepted");
  AST_LONG: assert property (
    link_req.valid && !link_req.diag && link_req.out_len > dout_len
    |=> !(link_rsp.ack inside {SDX_ACK_OK, SDX_ACK_HP}))
    else $error("long output accepted");
  AST_DUMMY: assert property (
    link_rsp.valid && link_rsp.ack == SDX_ACK_HP && din_len == 8'h00
    |-> link_rsp.dummy)
    else $error("dummy byte missing");
  AST_FETCH: assert property (
    reg_rd && reg_addr == `SDX_A_DOUT_FETCH |=> reg_rdata[7:4] == 4'h0)
    else $error("fetch upper bits set");
  AST_OSTATE: assert property (
    reg_rd && reg_addr == `SDX_A_DOUT_STATE |=> reg_rdata[1:0] != 2'b00)
    else $error("output data field nil");
  AST_PROV: assert property (
    reg_rd && reg_addr == `SDX_A_DIN_PROVIDE
    |=> reg_rdata[7:2] == 6'h00 && reg_rdata[1:0] != 2'b00)
    else $error("provide value bad");
  AST_ISTATE: assert property (
    reg_rd && reg_addr == `SDX_A_DIN_STATE
    |=> reg_rdata[5:4] != 2'b00 && reg_rdata[1:0] != 2'b00)
    else $error("input user or data nil");
  AST_WDEV: assert property (
    $rose(wd_expired_event) |=> !wd_expired_event [*4])
    else $error("expiry event repeated");
endmodule
bind sdx_core sdx_core_chk u_chk (.clk, .rst_n, .reg_addr, .reg_rd,
  .reg_rdata, .link_req, .link_rsp, .master_addr, .dout_len, .din_len,
  .diag_fetched_irq, .wd_expired_event);
`default_nettype wire

// ---- tb/sdx_master_model.sv ----
`default_nettype none
module sdx_master_model
  import sdx_pkg::*;
(
  // clock
  input wire logic clk,
  // frame order from the bench
  input wire logic go,
  input wire logic diag,
  input wire logic [7:0] src,
  input wire logic [7:0] len,
  // request toward the slave
  output sdx_req_t link_req
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle fields show the inverse of the last order, never its value
  always_ff @(posedge clk) begin
    link_req.valid <= go;
    link_req.diag <= go ? diag : ~diag;
    link_req.src_addr <= go ? src : ~src;
    link_req.out_len <= go ? len : ~len;
  end
endmodule
`default_nettype wire

// ---- tb/test_slave_diag_data_exchange.sv ----
`default_nettype none
`include "sdx_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
  end end
module test_slave_diag_data_exchange
  import sdx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] MA = 8'h02;
  localparam logic [7:0] DL = 8'h04;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0, diag = 1'b0, irq, wde;
  logic [7:0] src = 8'h00, len = 8'h00, din_len = 8'h02;
  logic [7:0] diag_raddr = 8'h00, diag_rdata;
  logic [31:0] seed = 32'h81a7e9c5;
  sdx_req_t link_req;
  sdx_rsp_t link_rsp;
  int n_mismatch = 0, cmp_count = 0;
  always #10 clk = ~clk;
  sdx_master_model pm (.clk, .go, .diag, .src, .len, .link_req);
  sdx_core #(.WD_TICK_CYC(10)) uut (.clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .link_req, .link_rsp,
    .master_addr(MA), .dout_len(DL), .din_len, .diag_raddr, .diag_rdata,
    .diag_fetched_irq(irq), .wd_expired_event(wde));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] st(input logic [1:0] f, u, n, b);
    return {f, u, n, b};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // diag buffer byte: address one edge, data registered the next
  task automatic dbyte(input logic [7:0] a);
    @(posedge clk);
    diag_raddr <= a;
    repeat (2) @(posedge clk);
    #1;
    d = diag_rdata;
  endtask
  // answer and fetched pulse stand one cycle after the model's frame
  task automatic req(input logic g, input logic [7:0] s, l);
    @(posedge clk);
    go <= 1'b1;
    diag <= g;
    src <= s;
    len <= l;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic done(input int k);
    $display("test %0d ended", k);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
  initial begin
    int k;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(`SDX_A_DOUT_STATE);
    `CHK(d, st(2'd3, 2'd2, 2'd0, 2'd1))
    rd(`SDX_A_DOUT_STATE);
    `CHK(d, st(2'd3, 2'd2, 2'd0, 2'd1))
    rd(`SDX_A_DIN_STATE);
    `CHK(d, st(2'd3, 2'd1, 2'd0, 2'd2))
    rd(`SDX_A_DOUT_FETCH);
    `CHK(d, 8'h02)
    rd(8'h3f);
    `CHK(d, 8'h00)
    rd(`SDX_A_STATUS);
    `CHK(d, 8'h00)
    done(1);
    wr(`SDX_A_REQUEST, `SDX_RQ_START);
    wr(`SDX_A_CONTROL, 8'h04);
    req(1'b0, MA, DL);
    `CHK(link_rsp.ack, SDX_ACK_RS)
    rd(`SDX_A_DIN_PROVIDE);
    `CHK(d, 8'h03)
    rd(`SDX_A_DIN_STATE);
    `CHK(d, st(2'd0, 2'd3, 2'd1, 2'd2))
    rd(`SDX_A_STATUS);
    `CHK(d[1], 1'b1)
    `CHK(d[0], 1'b1)
    done(2);
    req(1'b0, MA, DL);
    `CHK(link_rsp.ack, SDX_ACK_HP)
    req(1'b1, MA, 8'h00);
    `CHK(irq, 1'b1)
    req(1'b0, MA, DL);
    `CHK(link_rsp.ack, SDX_ACK_OK)
    rd(`SDX_A_DOUT_FETCH);
    `CHK(d[2], 1'b1)
    done(3);
    seed = lfsr(seed);
    wr(`SDX_A_CONTROL, 8'h05);
    wr(`SDX_A_DIAG_SWAP, seed[7:0] & 8'h08);
    rd(`SDX_A_STATUS);
    `CHK(d[0], 1'b1)
    `CHK(d[4], 1'b1)
    dbyte(8'(`SDX_DB_MADDR));
    `CHK(d, MA)
    dbyte(8'(`SDX_DB_STAT1));
    `CHK(d, seed[7:0] & 8'h08)
    dbyte(8'(`SDX_DB_STAT2));
    `CHK(d, 8'h06)
    @(posedge clk);
    din_len <= 8'h00;
    req(1'b0, MA, DL);
    `CHK(link_rsp.dummy, 1'b1)
    req(1'b1, MA, 8'h00);
    rd(`SDX_A_STATUS);
    `CHK(d[0], 1'b1)
    done(4);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      req(1'b0, seed[7:0] | 8'h80, DL);
      `CHK(link_rsp.ack, SDX_ACK_RS)
      req(1'b0, MA, DL + 8'h01 + {5'h00, seed[10:8]});
      `CHK(link_rsp.ack, SDX_ACK_NR)
    end
    req(1'b0, MA, DL - 8'h01);
    `CHK(link_rsp.valid, 1'b1)
    rd(`SDX_A_STATUS);
    `CHK(d[1], 1'b0)
    done(5);
    wr(`SDX_A_WD_RELOAD_LO, 8'h05);
    wr(`SDX_A_WD_RELOAD_HI, 8'h00);
    wr(`SDX_A_REQUEST, `SDX_RQ_WD_EN);
    repeat (30) @(posedge clk);
    wr(`SDX_A_REQUEST, `SDX_RQ_WD_RST);
    k = 0;
    while (wde !== 1'b1 && k < 200) begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(k >= 35 && k <= 65, 1'b1)
    rd(`SDX_A_STATUS);
    `CHK(d[3], 1'b1)
    done(6);
    wr(`SDX_A_REQUEST, `SDX_RQ_WD_EN);
    wr(`SDX_A_REQUEST, `SDX_RQ_WD_DIS);
    repeat (70) @(posedge clk);
    rd(`SDX_A_STATUS);
    `CHK(d[3:2], 2'b00)
    wr(`SDX_A_CONTROL, 8'h02);
    wr(`SDX_A_DIAG_SWAP, 8'h00);
    wr(`SDX_A_WD_RELOAD_LO, 8'h01);
    wr(`SDX_A_REQUEST, `SDX_RQ_WD_EN);
    repeat (40) @(posedge clk);
    rd(`SDX_A_STATUS);
    `CHK(d[4], 1'b0)
    `CHK(d[0], 1'b0)
    `CHK(d[3], 1'b1)
    done(7);
    conclude();
  end
endmodule
`default_nettype wire
